// >>> sac_pkg.sv
// constants shared by the serial converter control sequencer
package sac_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int RES_W = 10;
    localparam int ADDR_W = 4;
    localparam int N_CH = 14;
    localparam int CNT_W = 5;
    // ------------------------------------------------------------
    // shift clock edge positions within a transfer
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] ADDR_RISES = 5'h04;
    localparam logic [CNT_W-1:0] SAMPLE_FALL = 5'h04;
    localparam logic [CNT_W-1:0] HOLD_FALL = 5'h0A;
    localparam logic [CNT_W-1:0] LONG_FALLS = 5'h10;
    // ------------------------------------------------------------
    // channel codes
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CH_IN_ZERO = 4'h0;
    localparam logic [ADDR_W-1:0] CH_IN_TEN = 4'hA;
    localparam logic [ADDR_W-1:0] CH_REF_MID = 4'hB;
    localparam logic [ADDR_W-1:0] CH_REF_LO = 4'hC;
    localparam logic [ADDR_W-1:0] CH_REF_HI = 4'hD;
    // ------------------------------------------------------------
    // timing: select rise to input disable
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int CS_SETUP_NS = 100;
    localparam int SYS_FALLS = 2;
    localparam int CS_DIS_INT = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS + SYS_FALLS;
    localparam logic [2:0] CS_DIS_CYC = 3'(CS_DIS_INT);
endpackage : sac_pkg

// >>> sac_sar.sv
// successive approximation engine for the serial converter
`timescale 1ns/1ns
module sac_sar #(
    parameter int BIT_CYC = 4
) (
    input wire logic ref_clk,                          // system clock
    input wire logic nrst,                             // sync reset, low
    input wire logic clk_en,                           // freezes state
    input wire logic start,                            // hold taken
    input wire logic cmp_below,                        // summing node low
    output logic busy,                                 // converting
    output logic done,                                 // result ready pulse
    output logic [sac_pkg::RES_W-1:0] trial,           // trial code to dac
    output logic [sac_pkg::RES_W-1:0] result           // last result
);
    import sac_pkg::*;

    typedef struct packed {
        logic busy;
        logic done;
        logic [3:0] idx;
        logic [7:0] tick;
        logic [RES_W-1:0] acc;
        logic [RES_W-1:0] trial;
        logic [RES_W-1:0] res;
    } sac_sar_st_t;

    sac_sar_st_t s_ff, nxt_s;

    // elaboration check: the tick counter is eight bits wide
    if (BIT_CYC < 1 || BIT_CYC > 255) begin : g_bad_bit_cyc
        $error("sac_sar: BIT_CYC out of range");
    end

    // ------------------------------------------------------------
    // bit stepping
    // ------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        if (clk_en) begin
            // done lasts one enabled cycle so a freeze cannot lose it
            nxt_s.done = 1'b0;
            if (start) begin
                nxt_s.busy = 1'b1;
                nxt_s.idx = 4'h9;
                nxt_s.tick = 8'h00;
                nxt_s.acc = '0;
                nxt_s.trial = RES_W'(1) << 9;
            end else if (s_ff.busy) begin
                if (s_ff.tick == 8'(BIT_CYC - 1)) begin
                    nxt_s.tick = 8'h00;
                    if (cmp_below)
                        nxt_s.acc[s_ff.idx] = 1'b1;
                    if (s_ff.idx == 4'h0) begin
                        nxt_s.busy = 1'b0;
                        nxt_s.done = 1'b1;
                        nxt_s.res = nxt_s.acc;
                        nxt_s.trial = '0;
                    end else begin
                        nxt_s.idx = s_ff.idx - 4'h1;
                        nxt_s.trial = nxt_s.acc | (RES_W'(1) << nxt_s.idx);
                    end
                end else begin
                    nxt_s.tick = s_ff.tick + 8'h01;
                end
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (!nrst)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign busy = s_ff.busy;
    assign done = s_ff.done;
    assign trial = s_ff.trial;
    assign result = s_ff.res;

    property p_sar_msb;
        @(posedge ref_clk) disable iff (!nrst)
        (start && clk_en) |=> (trial == (RES_W'(1) << 9)) && busy;
    endproperty
    a_sar_msb: assert property (p_sar_msb)
        else $error("first trial is not the msb weight");
endmodule : sac_sar

// >>> sac_ctrl.sv
// serial control sequencer of a 10-bit successive approximation converter
// How it works
// - mode 2 later transfers are exactly 10 clocks with select low
// - fast select-low modes: conversion done releases output showing msb
// - select fall starts sequence, output leaves high impedance
// - select rise ends sequence, output back to high impedance
// - clock and address ignored a setup plus two cycles after rise
// - done during an unfinished transfer marks a slow cycle
// - slow mode needs eleventh rise before done; select toggle recovers
// - slow select-low: sixteenth fall releases output showing msb
// - address taken msb first on first four rises, for next conversion
// - codes zero to ten pick external inputs in order
// - codes eleven to thirteen pick reference mid, low, high
// - multiplexer breaks old input before making new one
// - sample from fourth fall for six periods, hold at tenth fall
// - ten bits resolved msb first, bit kept when below threshold
// - done flag low at tenth fall, high when result ready
// - remaining nine bits shift out on next nine falls
// - output forced low at tenth fall, extra clocks read zero
`timescale 1ns/1ns
module sac_ctrl #(
    parameter int BIT_CYC = 4
) (
    input wire logic ref_clk,                          // system clock
    input wire logic nrst,                             // sync reset, low
    input wire logic clk_en,                           // freezes all state
    input wire logic cs_n,                             // chip select pin
    input wire logic io_clk,                           // host shift clock
    input wire logic addr_in,                          // channel address pin
    input wire logic cmp_below,                        // comparator result
    output logic dout,                                 // result output
    output logic dout_oe_n,                            // low while driving
    output logic eoc,                                  // conversion done
    output logic sample_en,                            // sample switch closed
    output logic mux_on,                               // multiplexer made
    output logic [sac_pkg::ADDR_W-1:0] mux_sel,        // selected code
    output logic [sac_pkg::N_CH-1:0] chan_onehot,      // input switch enables
    output logic [sac_pkg::RES_W-1:0] dac_trial        // trial code
);
    import sac_pkg::*;

    typedef struct packed {
        logic cs_s1, cs_s2, cs_p;
        logic ck_s1, ck_s2, ck_p;
        logic ad_s1, ad_s2;
        logic en;
        logic [2:0] dis_cnt;
        logic [CNT_W-1:0] rise_cnt;
        logic [CNT_W-1:0] fall_cnt;
        logic [ADDR_W-1:0] addr_sr;
        logic [ADDR_W-1:0] pend_sel;
        logic pend;
        logic [ADDR_W-1:0] sel;
        logic mux_on;
        logic sample;
        logic eoc;
        logic [RES_W-1:0] out_sr;
        logic oe_n;
        logic slow;
        logic start;
    } sac_ctl_st_t;

    sac_ctl_st_t s_ff, nxt_s;
    logic cs_fall, cs_rise, ck_rise, ck_fall;
    logic sar_done;
    logic [RES_W-1:0] sar_res;
    logic [CNT_W-1:0] f_new;

    // ------------------------------------------------------------
    // converter engine
    // ------------------------------------------------------------
    sac_sar #(.BIT_CYC(BIT_CYC)) u_sar (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .start(s_ff.start),
        .cmp_below(cmp_below),
        .busy(),
        .done(sar_done),
        .trial(dac_trial),
        .result(sar_res)
    );

    // pin edges seen after the two-stage synchronisers
    assign cs_fall = !s_ff.cs_s2 && s_ff.cs_p;
    assign cs_rise = s_ff.cs_s2 && !s_ff.cs_p;
    assign ck_rise = s_ff.ck_s2 && !s_ff.ck_p && s_ff.en;
    assign ck_fall = !s_ff.ck_s2 && s_ff.ck_p && s_ff.en;
    assign f_new = s_ff.fall_cnt + 5'h01;

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        if (clk_en) begin
            // start lasts one enabled cycle so a freeze cannot lose it
            nxt_s.start = 1'b0;
            nxt_s.cs_s1 = cs_n;
            nxt_s.cs_s2 = s_ff.cs_s1;
            nxt_s.cs_p = s_ff.cs_s2;
            nxt_s.ck_s1 = io_clk;
            nxt_s.ck_s2 = s_ff.ck_s1;
            nxt_s.ck_p = s_ff.ck_s2;
            nxt_s.ad_s1 = addr_in;
            nxt_s.ad_s2 = s_ff.ad_s1;
            if (cs_fall) begin
                nxt_s.en = 1'b1;
                nxt_s.oe_n = 1'b0;
                nxt_s.rise_cnt = '0;
                nxt_s.fall_cnt = '0;
                nxt_s.slow = 1'b0;
                nxt_s.out_sr = sar_res;
            end else begin
                if (cs_rise) begin
                    nxt_s.oe_n = 1'b1;
                    nxt_s.dis_cnt = 3'h0;
                end else if (s_ff.cs_p && s_ff.en) begin
                    nxt_s.dis_cnt = s_ff.dis_cnt + 3'h1;
                    if (nxt_s.dis_cnt >= CS_DIS_CYC)
                        nxt_s.en = 1'b0;
                end
                if (ck_rise && s_ff.rise_cnt < LONG_FALLS) begin
                    nxt_s.rise_cnt = s_ff.rise_cnt + 5'h01;
                    if (s_ff.rise_cnt < ADDR_RISES)
                        nxt_s.addr_sr = {s_ff.addr_sr[ADDR_W-2:0], s_ff.ad_s2};
                end
                if (ck_fall && s_ff.fall_cnt < LONG_FALLS) begin
                    nxt_s.fall_cnt = f_new;
                    if (f_new < HOLD_FALL)
                        nxt_s.out_sr = {s_ff.out_sr[RES_W-2:0], 1'b0};
                    if (f_new == SAMPLE_FALL) begin
                        nxt_s.sample = 1'b1;
                        nxt_s.pend = 1'b1;
                        nxt_s.pend_sel = s_ff.addr_sr;
                    end
                    if (f_new == HOLD_FALL) begin
                        nxt_s.sample = 1'b0;
                        nxt_s.start = 1'b1;
                        nxt_s.eoc = 1'b0;
                        nxt_s.out_sr = '0;
                    end
                    if (f_new == LONG_FALLS && s_ff.slow && !s_ff.cs_s2) begin
                        nxt_s.out_sr = sar_res;
                        nxt_s.rise_cnt = '0;
                        nxt_s.fall_cnt = '0;
                        nxt_s.slow = 1'b0;
                    end
                end
            end
            if (sar_done) begin
                nxt_s.eoc = 1'b1;
                if (!s_ff.cs_s2) begin
                    if (s_ff.fall_cnt == LONG_FALLS ||
                        (s_ff.fall_cnt == HOLD_FALL &&
                         s_ff.rise_cnt == HOLD_FALL)) begin
                        nxt_s.out_sr = sar_res;
                        nxt_s.rise_cnt = '0;
                        nxt_s.fall_cnt = '0;
                    end else if (s_ff.fall_cnt >= HOLD_FALL) begin
                        nxt_s.slow = 1'b1;
                    end
                end
            end
            if (s_ff.pend && s_ff.mux_on) begin
                nxt_s.mux_on = 1'b0;
            end else if (s_ff.pend) begin
                nxt_s.sel = s_ff.pend_sel;
                nxt_s.pend = 1'b0;
            end else if (!s_ff.mux_on && s_ff.sel <= CH_REF_HI) begin
                nxt_s.mux_on = 1'b1;
            end
        end
    end

    // state register with idle pin levels at reset
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s_ff <= '0;
            s_ff.cs_s1 <= 1'b1;
            s_ff.cs_s2 <= 1'b1;
            s_ff.cs_p <= 1'b1;
            s_ff.eoc <= 1'b1;
            s_ff.oe_n <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign dout = s_ff.out_sr[RES_W-1];
    assign dout_oe_n = s_ff.oe_n;
    assign eoc = s_ff.eoc;
    assign sample_en = s_ff.sample;
    assign mux_on = s_ff.mux_on;
    assign mux_sel = s_ff.sel;

    for (genvar i = 0; i < N_CH; i++) begin : g_ch
        assign chan_onehot[i] = s_ff.mux_on && (s_ff.sel == ADDR_W'(i));
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_cs_fall;
        @(posedge ref_clk) disable iff (!nrst)
        (cs_fall && clk_en) |=> !dout_oe_n && dout == sar_res[RES_W-1];
    endproperty
    a_cs_fall: assert property (p_cs_fall)
        else $error("select fall did not drive msb");

    property p_cs_rise;
        @(posedge ref_clk) disable iff (!nrst)
        (cs_rise && clk_en) |=> dout_oe_n;
    endproperty
    a_cs_rise: assert property (p_cs_rise)
        else $error("select rise did not release output");

    property p_dis;
        @(posedge ref_clk) disable iff (!nrst)
        (cs_rise && clk_en) ##1 (clk_en && s_ff.cs_s2)[*4] |=> !s_ff.en;
    endproperty
    a_dis: assert property (p_dis)
        else $error("inputs still enabled after select rise");

    property p_hold;
        @(posedge ref_clk) disable iff (!nrst)
        (ck_fall && clk_en && f_new == HOLD_FALL)
            |=> !eoc && !sample_en && !dout && s_ff.start;
    endproperty
    a_hold: assert property (p_hold)
        else $error("tenth fall did not hold, start and force low");

    property p_sample;
        @(posedge ref_clk) disable iff (!nrst)
        (ck_fall && clk_en && f_new == SAMPLE_FALL) |=> sample_en;
    endproperty
    a_sample: assert property (p_sample)
        else $error("sampling did not open at fourth fall");

    property p_eoc_rise;
        @(posedge ref_clk) disable iff (!nrst)
        (sar_done && clk_en) |=> eoc;
    endproperty
    a_eoc_rise: assert property (p_eoc_rise)
        else $error("done flag not raised with result");

    property p_fast_msb;
        @(posedge ref_clk) disable iff (!nrst)
        (sar_done && clk_en && !s_ff.cs_s2 && s_ff.fall_cnt == LONG_FALLS)
            |=> dout == $past(sar_res[RES_W-1]) && s_ff.fall_cnt == '0;
    endproperty
    a_fast_msb: assert property (p_fast_msb)
        else $error("fast mode msb not shown at done");

    property p_bbm;
        @(posedge ref_clk) disable iff (!nrst)
        (mux_sel != $past(mux_sel)) |-> !mux_on && !$past(mux_on);
    endproperty
    a_bbm: assert property (p_bbm)
        else $error("selection changed while connected");

    property p_reserved;
        @(posedge ref_clk) disable iff (!nrst)
        mux_on |-> mux_sel <= CH_REF_HI && $onehot(chan_onehot);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved code connected an input");
endmodule : sac_ctrl

// >>> sac_host_model.sv
// host serial port master model: select, shift clock and address lines
`timescale 1ns/1ns
module sac_host_model (
    input wire logic ref_clk,    // system clock, paces the host
    input wire logic data_line,  // resolved result line
    input wire logic sample_en,  // sample switch, observed only
    input wire logic eoc,        // conversion done
    output logic cs_n,           // chip select, low active
    output logic io_clk,         // shift clock, still between frames
    output logic addr_in         // channel address
);
    // lines idle: select high, clock low
    initial begin
        cs_n = 1'b1;
        io_clk = 1'b0;
        addr_in = 1'b0;
    end

    // moves select, then leaves the synchronisers time to settle
    task automatic select(input logic lvl);
        cs_n <= lvl;
        repeat (6) @(negedge ref_clk);
    endtask : select

    // one transfer of n shift clocks, 800 ns each; sampled before each rise
    task automatic xfer(input logic [3:0] code, input int n, input int pause_at,
                        output logic [15:0] rd, output logic [15:0] sm,
                        output logic [15:0] ec);
        logic [3:0] sh;
        int i;
        int w;
        sh = code;
        rd = '0;
        sm = '0;
        ec = '0;
        addr_in <= sh[3];
        repeat (2) @(negedge ref_clk);
        for (i = 0; i < n; i++) begin
            // eleventh rise done early, rest waits for done
            if (pause_at != 0 && i == pause_at) begin
                for (w = 0; w < 300 && eoc !== 1'b1; w++) begin
                    @(negedge ref_clk);
                end
                repeat (4) @(negedge ref_clk);
            end
            rd[i] = data_line;
            sm[i] = sample_en;
            ec[i] = eoc;
            io_clk <= 1'b1;
            repeat (4) @(negedge ref_clk);
            io_clk <= 1'b0;
            sh = sh << 1;
            // next address bit, then a toggling line once released
            addr_in <= (i < 3) ? sh[3] : ~addr_in;
            repeat (4) @(negedge ref_clk);
        end
    endtask : xfer
endmodule : sac_host_model

// >>> tb.sv
// self-checking testbench of the serial converter control sequencer
`timescale 1ns/1ns
module tb;
    import sac_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic cmp_below = 1'b0;
    logic clk_en = 1'b1;
    logic [RES_W-1:0] vin = '0;
    logic cs_n, io_clk, addr_in;
    logic dout, dout_oe_n, eoc, sample_en, mux_on;
    logic [ADDR_W-1:0] mux_sel;
    logic [N_CH-1:0] chan_onehot;
    logic [RES_W-1:0] dac_trial;
    logic [RES_W-1:0] prev = '0;
    logic [15:0] rd, sm, ec;
    bit chk = 1'b0;
    int errors = 0;
    int n_compared = 0;
    wire data_line = dout_oe_n ? 1'bz : dout; // line released when off

    // --------------------------------------------------------------
    // clock, design and host
    // --------------------------------------------------------------
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    sac_ctrl #(.BIT_CYC(8)) dut (
        .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .cs_n(cs_n),
        .io_clk(io_clk), .addr_in(addr_in), .cmp_below(cmp_below),
        .dout(dout), .dout_oe_n(dout_oe_n), .eoc(eoc),
        .sample_en(sample_en), .mux_on(mux_on), .mux_sel(mux_sel),
        .chan_onehot(chan_onehot), .dac_trial(dac_trial)
    );

    sac_host_model host (
        .ref_clk(ref_clk), .data_line(data_line), .sample_en(sample_en),
        .eoc(eoc), .cs_n(cs_n), .io_clk(io_clk), .addr_in(addr_in)
    );

    // analog level seen on each channel code
    function automatic logic [RES_W-1:0] vval(input logic [3:0] c);
        case (c)
            CH_REF_MID: return 10'h200;
            CH_REF_LO: return 10'h000;
            CH_REF_HI: return 10'h3FF;
            default: return 10'(c) * 10'h05D + 10'h011;
        endcase
    endfunction : vval

    // comparator keeps a bit while trial not above input
    always @(negedge ref_clk) begin
        if (sample_en === 1'b1) vin <= vval(mux_sel);
        cmp_below <= (dac_trial <= vin);
    end

    // never two input switches made at once
    always @(negedge ref_clk) begin
        if (nrst) begin
            check("onehot", 16'($countones(chan_onehot) < 2), 16'h1);
        end
    end

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    task automatic wait_eoc();
        int w;
        for (w = 0; w < 300 && eoc !== 1'b1; w++) begin
            @(negedge ref_clk);
        end
        check("done high", 16'(eoc), 16'h1);
    endtask : wait_eoc

    // one transfer, judged on bits, sample window and done flag
    task automatic frame(input logic [3:0] a, input int n, input int p);
        logic [15:0] m, e;
        int i;
        host.xfer(a, n, p, rd, sm, ec);
        m = 16'hFFFF >> (16 - n);
        e = '0;
        for (i = 0; i < 10; i++) e[i] = prev[9 - i];
        if (chk) check("result bits", rd & m, e);
        check("sample window", sm & m, 16'h03F0);
        if (n > 10) check("done low", 16'(ec[10]), 16'h0);
        if (n == 10) check("done, line low", 16'({eoc, data_line}), 16'h0);
        prev = vval(a);
        chk = 1'b1;
    endtask : frame

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_toggle();
        int c;
        for (c = 0; c < 14; c++) begin
            host.select(1'b0);
            check("driving", 16'(dout_oe_n), 16'h0);
            // lengths 10 to 16, two of them slow
            frame(4'(c), 10 + c % 7, (c % 7 == 5) ? 11 : 0);
            host.select(1'b1);
            check("released", 16'(dout_oe_n), 16'h1);
            check("input switch", 16'(chan_onehot), 16'(1 << c));
            wait_eoc();
        end
        $display("test select toggled done");
    endtask : t_toggle

    task automatic t_stray();
        // clocks with select high are ignored
        host.xfer(4'h2, 12, 0, rd, sm, ec);
        check("stray done", 16'(eoc), 16'h1);
        check("stray code", 16'(mux_sel), 16'(CH_REF_HI));
        $display("test stray clocks done");
    endtask : t_stray

    // clock enable low holds a running conversion, then it resumes
    task automatic t_freeze();
        logic [RES_W-1:0] held;
        host.select(1'b0);
        frame(4'h3, 10, 0);
        host.select(1'b1);
        clk_en <= 1'b0;
        @(negedge ref_clk);
        held = dac_trial;
        repeat (100) @(negedge ref_clk);
        check("frozen done", 16'(eoc), 16'h0);
        check("frozen trial", 16'(dac_trial), 16'(held));
        clk_en <= 1'b1;
        wait_eoc();
        $display("test clock enable freeze done");
    endtask : t_freeze

    // both reserved codes leave every input switch open
    task automatic t_reserved();
        int r;
        for (r = 14; r < 16; r++) begin
            host.select(1'b0);
            frame(4'(r), 16, 0);
            host.select(1'b1);
            check("reserved mux", 16'({mux_on, chan_onehot}), 16'h0);
            wait_eoc();
            chk = 1'b0;
        end
        $display("test reserved code done");
    endtask : t_reserved

    // select held low: n 10 or 16, slow when p set
    task automatic t_low(input int n, input int p);
        int k;
        host.select(1'b0);
        for (k = 0; k < 3; k++) begin
            // exact lengths with select held low
            frame(4'(1 + 4 * k + n % 3), n, p);
            if (p != 0) begin
                check("msb at last fall", 16'(data_line), 16'(prev[9]));
            end else begin
                wait_eoc();
                check("msb at done", 16'(data_line), 16'(prev[9]));
            end
        end
        host.select(1'b1);
        wait_eoc();
        $display("test select low %0d clocks done", n);
    endtask : t_low

    // --------------------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        repeat (20) @(negedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        check("oe at reset", 16'(dout_oe_n), 16'h1);
        check("done at reset", 16'(eoc), 16'h1);
        t_toggle();
        t_stray();
        t_freeze();
        t_reserved();
        t_low(10, 0);
        t_low(16, 0);
        t_low(16, 11);
        summarize();
    end

    initial begin
        #2000000;
        errors++;
        $display("Error watchdog expected finish seen hang");
        summarize();
    end
endmodule : tb
